// ===== rtl/rpsem_top.sv
// Selector channel position-mode command interpreter with APB registers
//
// Overview of operation
// - State code op: 00 invalid, 01 enter, 10 reconnect, 11 retry reconnect.
// - State code not matching drive state ends CE DE UC, invalid sequence.
// - Drive in state 2 or 3: other commands except test I/O get UC.
// - In position mode, seeks and recalibrate needing motion end CE UC UE.
// - Motion completion starts selection toward channel and posts device end.
// - Set sector disconnects, or ends CE DE when at target minus seven.
// - Idle loop raises request in while a drive interrupt window is active.
// - Selector reconnect request comes five sectors before block multiplex.
// - Diagnostic, sense, read, write and search commands run unchanged.
// - Disconnected drive keeps chaining state; next command is chained.
// - Poll selects lowest numbered chaining drive with an interrupt.
// - After stacked device end, disconnect and keep chaining state.
// - Test I/O on stacked drive posts device end and clears its interrupt.
// - Contingent wait rejects other devices with UC, other channels busy.
// - Reconnect state code ends CE DE; channel chains onward.
// - Retry status keeps simulated chaining; next command is the retry.
// - Retry reconnect waits contingent, then enters chained reselection.
// - Outside position mode motion gives CE, stays connected, then DE.
// - Outside position mode retry becomes CE DE UC, sense overrun.
// - Sense format: uncorrectable 4, correctable 5, seek 1A, overrun 0.
// - Outside position mode, internal recoveries show no retry status.
// - Position-mode command code is 2F hex.
// - State code op is bits 0 and 1; bits 2 to 7 must be zero.
// - Position-mode command on block multiplex channel: UC, invalid command.
// - Short byte count: UC, command reject count less than required.
`timescale 1ns/1ps
module rpsem_top
    import rpsem_pkg::*;
#(
    parameter int WIN = WIN_CYC
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic [7:0]      paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            cmd_valid,
    input  wire logic [7:0]      cmd_op,
    input  wire logic [7:0]      cmd_arg,
    input  wire logic [2:0]      cmd_drive,
    input  wire logic            cmd_count_ok,
    input  wire logic            cmd_other_chan,
    input  wire logic            need_motion,
    input  wire logic            sector_ready,
    input  wire logic            retry_cond,
    input  wire logic [1:0]      err_cause,
    input  wire logic            recov_internal,
    input  wire logic            select_out,
    input  wire logic            address_out,
    input  wire logic            stack_in,
    input  wire logic [NDRV-1:0] motion_done,
    input  wire logic [NDRV-1:0] sector_hit,
    output logic                 sts_valid,
    output logic [7:0]           sts_byte,
    output logic                 sts_chained,
    output logic                 retry_cmd,
    output logic                 request_in,
    output logic                 sel_valid,
    output logic [2:0]           sel_drive,
    output logic [7:0]           sect_target
);
    typedef struct packed {
        rpsem_fsm_t        fsm;
        logic [2:0]        drv;
        logic              sts_v;
        logic [7:0]        sts;
        logic              chn;
        logic              rty;
        logic              sel_v;
        logic [NDRV-1:0]   chain;
        logic [NDRV-1:0]   rpend;
        logic [31:0]       sns;
        logic [31:0]       ctrl;
        logic [31:0]       rdata;
        logic              err;
        logic [7:0]        sect;
    } rpsem_top_t;

    rpsem_top_t s_q, s_d;
    rpsem_drv_if di ();

    rpsem_drv_tbl #(.WIN(WIN)) u_tbl (
        .pclk        (pclk),
        .presetn     (presetn),
        .motion_done (motion_done),
        .sector_hit  (sector_hit),
        .t           (di.tbl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command decode helpers

    logic       selch;
    logic [1:0] dst;
    logic       rotational_position_mode;
    logic       motion_op;
    logic [1:0] scop;
    logic       sczero;
    logic [7:0] fmt;

    always_comb begin
        selch = s_q.ctrl[0];
        dst = di.st[cmd_drive];
        rotational_position_mode = dst != DS_IDLE;
        motion_op = cmd_op == OP_SEEK || cmd_op == OP_SEEKCYL
                    || cmd_op == OP_RECAL;
        scop = cmd_arg[1:0];
        sczero = cmd_arg[7:2] == 6'd0;
        case (err_cause)
            EC_SEEK:   fmt = FM_SEEK;
            EC_UNCORR: fmt = FM_UNCORR;
            EC_CORR:   fmt = FM_CORR;
            default:   fmt = FM_OVR;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and register file

    logic [31:0] stat_word;

    always_comb begin
        s_d = s_q;
        s_d.sts_v = 1'b0;
        s_d.chn = 1'b0;
        s_d.sel_v = 1'b0;
        di.wr = 1'b0;
        di.wr_drv = cmd_drive;
        di.wr_st = DS_IDLE;
        di.clr = 1'b0;
        di.clr_drv = cmd_drive;
        stat_word = {8'h00, di.st, 5'd0, s_q.fsm};

        // Poll, stacked status and connected motion handshake with the channel
        case (s_q.fsm)
            FS_IDLE: begin
                if (request_in && select_out && !address_out
                    && di.low_ok) begin
                    s_d.fsm = FS_SEL;
                    s_d.drv = di.low_drv;
                    s_d.sel_v = 1'b1;
                end
            end
            FS_SEL: begin
                s_d.sts_v = 1'b1;
                s_d.sts = ST_DE;
                s_d.fsm = FS_STK;
            end
            FS_STK: begin
                // Stacked: disconnect, drive keeps chaining state
                if (stack_in)
                    s_d.fsm = FS_IDLE;
            end
            FS_MOT: begin
                // Selector stays connected through motion
                if (motion_done[s_q.drv]) begin
                    s_d.sts_v = 1'b1;
                    s_d.sts = ST_DE;
                    s_d.fsm = FS_IDLE;
                end
            end
            FS_CONT: ;
            default: s_d.fsm = FS_IDLE;
        endcase

        if (cmd_valid) begin
            s_d.sts_v = 1'b1;
            s_d.sts = ST_CE | ST_DE;
            s_d.rty = 1'b0;
            // Next command after a reconnect continues the old chain
            s_d.chn = s_q.chain[cmd_drive];
            s_d.chain[cmd_drive] = 1'b0;
            if (s_q.rpend[cmd_drive] && cmd_op != OP_POSMODE) begin
                s_d.rty = 1'b1;
                s_d.rpend[cmd_drive] = 1'b0;
            end
            if (s_q.fsm == FS_CONT && cmd_drive != s_q.drv) begin
                // Contingent connection holds the unit
                s_d.sts = cmd_other_chan ? ST_BY : ST_UC;
                s_d.chn = 1'b0;
                s_d.rty = 1'b0;
                s_d.chain[cmd_drive] = s_q.chain[cmd_drive];
                s_d.rpend[cmd_drive] = s_q.rpend[cmd_drive];
            end else if (cmd_op == OP_POSMODE) begin
                if (!selch) begin
                    s_d.sts = ST_UC;
                    s_d.sns = {SN_CMDREJ, SN_INVCMD, 16'h0000};
                end else if (!cmd_count_ok) begin
                    s_d.sts = ST_UC;
                    s_d.sns = {SN_CMDREJ, SN_SHORT, 16'h0000};
                end else if (!sczero || scop == SC_INVALID) begin
                    s_d.sts = ST_CE | ST_DE | ST_UC;
                    s_d.sns = {SN_CMDREJ, SN_INVSEQ, 16'h0000};
                end else if ((scop == SC_ENTER && dst != DS_IDLE)
                    || (scop == SC_RECON && dst != DS_DCC)
                    || (scop == SC_RETRY && dst != DS_RTY)) begin
                    s_d.sts = ST_CE | ST_DE | ST_UC;
                    s_d.sns = {SN_CMDREJ, SN_INVSEQ, 16'h0000};
                end else begin
                    // Valid code: drive back into plain position mode
                    di.wr = 1'b1;
                    di.wr_st = DS_INIT;
                    s_d.sts = ST_CE | ST_DE;
                    s_d.chain[cmd_drive] = scop != SC_ENTER;
                    s_d.rpend[cmd_drive] = scop == SC_RETRY;
                    if (s_q.fsm == FS_CONT)
                        s_d.fsm = FS_IDLE;
                end
            end else if (dst >= DS_DCC && cmd_op != OP_TIO) begin
                s_d.sts = ST_UC;
                s_d.sns = {SN_CMDREJ, SN_INVSEQ, 16'h0000};
                s_d.chn = 1'b0;
                s_d.rty = 1'b0;
            end else if (cmd_op == OP_TIO) begin
                s_d.sts = 8'h00;
                if (di.int_act[cmd_drive] && dst >= DS_DCC) begin
                    s_d.sts = ST_DE;
                    di.clr = 1'b1;
                    s_d.drv = cmd_drive;
                    s_d.fsm = FS_CONT;
                end
            end else if (cmd_op == OP_DIAGLD || cmd_op == OP_DIAGWR) begin
                s_d.sts = ST_CE | ST_DE;
            end else if (retry_cond && !recov_internal) begin
                if (rotational_position_mode && selch) begin
                    s_d.sts = ST_SM | ST_CE | ST_UC;
                    di.wr = 1'b1;
                    di.wr_st = DS_RTY;
                end else begin
                    s_d.sts = ST_CE | ST_DE | ST_UC;
                    s_d.sns = {SN_OVERRUN, 16'h0000, fmt};
                end
            end else if (retry_cond) begin
                s_d.sts = ST_CE | ST_DE;
            end else if ((motion_op && need_motion)
                || (cmd_op == OP_SETSECT && !sector_ready)) begin
                if (cmd_op == OP_SETSECT)
                    // Drive is told where to interrupt
                    s_d.sect = cmd_arg - (selch ? LEAD_SEL
                                          : LEAD_SEL - LEAD_EARLY);
                if (rotational_position_mode && selch) begin
                    s_d.sts = ST_CE | ST_UC | ST_UE;
                    di.wr = 1'b1;
                    di.wr_st = DS_DCC;
                end else begin
                    s_d.sts = ST_CE;
                    s_d.drv = cmd_drive;
                    s_d.fsm = FS_MOT;
                end
            end
        end

        // APB: zero wait states, read data captured in the setup cycle
        s_d.err = 1'b0;
        if (psel && !penable) begin
            s_d.rdata = 32'h0000_0000;
            case (paddr)
                A_CTRL:  s_d.rdata = s_q.ctrl;
                A_STAT:  s_d.rdata = stat_word;
                A_SENSE: s_d.rdata = s_q.sns;
                A_LAST:  s_d.rdata = {24'h000000, s_q.sts};
                default: s_d.err = 1'b1;
            endcase
        end else if (psel) begin
            s_d.err = s_q.err;
        end
        if (psel && penable && pwrite && paddr == A_CTRL)
            s_d.ctrl = {31'd0, pwdata[0]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        prdata = s_q.rdata;
        pready = 1'b1;
        pslverr = psel && penable && s_q.err;
        sts_valid = s_q.sts_v;
        sts_byte = s_q.sts;
        sts_chained = s_q.chn;
        retry_cmd = s_q.rty;
        // Request only from the idle loop; never during contingent wait
        request_in = s_q.fsm == FS_IDLE && di.low_ok;
        sel_valid = s_q.sel_v;
        sel_drive = s_q.drv;
        sect_target = s_q.sect;
    end
endmodule

// ===== rtl/rpsem_pkg.sv
// Constants and types for the selector channel position-mode emulation
package rpsem_pkg;
    localparam int NDRV = 8;
    // Command operation codes
    localparam logic [7:0] OP_POSMODE = 8'h2F;
    localparam logic [7:0] OP_TIO     = 8'h00;
    localparam logic [7:0] OP_SEEK    = 8'h07;
    localparam logic [7:0] OP_SEEKCYL = 8'h0B;
    localparam logic [7:0] OP_RECAL   = 8'h13;
    localparam logic [7:0] OP_SETSECT = 8'h23;
    localparam logic [7:0] OP_DIAGLD  = 8'h53;
    localparam logic [7:0] OP_DIAGWR  = 8'h73;
    // State code operation field
    localparam logic [1:0] SC_INVALID = 2'b00;
    localparam logic [1:0] SC_ENTER   = 2'b01;
    localparam logic [1:0] SC_RECON   = 2'b10;
    localparam logic [1:0] SC_RETRY   = 2'b11;
    // Status byte bits
    localparam logic [7:0] ST_SM = 8'h40;
    localparam logic [7:0] ST_CU = 8'h20;
    localparam logic [7:0] ST_BY = 8'h10;
    localparam logic [7:0] ST_CE = 8'h08;
    localparam logic [7:0] ST_DE = 8'h04;
    localparam logic [7:0] ST_UC = 8'h02;
    localparam logic [7:0] ST_UE = 8'h01;
    // Sense bytes 0..2 and format/message byte
    localparam logic [7:0] SN_CMDREJ  = 8'h80;
    localparam logic [7:0] SN_OVERRUN = 8'h04;
    localparam logic [7:0] SN_INVCMD  = 8'h01;
    localparam logic [7:0] SN_INVSEQ  = 8'h02;
    localparam logic [7:0] SN_SHORT   = 8'h04;
    localparam logic [7:0] FM_OVR     = 8'h00;
    localparam logic [7:0] FM_SEEK    = 8'h1A;
    localparam logic [7:0] FM_UNCORR  = 8'h40;
    localparam logic [7:0] FM_CORR    = 8'h50;
    // Error causes
    localparam logic [1:0] EC_OVR    = 2'd0;
    localparam logic [1:0] EC_SEEK   = 2'd1;
    localparam logic [1:0] EC_UNCORR = 2'd2;
    localparam logic [1:0] EC_CORR   = 2'd3;
    // Sector lead: selector leads block multiplex by five sectors
    localparam logic [7:0] LEAD_SEL  = 8'h07;
    localparam logic [7:0] LEAD_EARLY = 8'h05;
    // Drive interrupt window
    localparam int WIN_NS  = 130000;
    localparam int CLK_NS  = 10;
    localparam int WIN_CYC = WIN_NS / CLK_NS;
    // Register offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_SENSE = 8'h08;
    localparam logic [7:0] A_LAST  = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    typedef enum logic [1:0] {
        DS_IDLE = 2'd0,
        DS_INIT = 2'd1,
        DS_DCC  = 2'd2,
        DS_RTY  = 2'd3
    } rpsem_dst_t;

    typedef enum logic [2:0] {
        FS_IDLE = 3'b000,
        FS_SEL  = 3'b001,
        FS_STK  = 3'b011,
        FS_CONT = 3'b010,
        FS_MOT  = 3'b110
    } rpsem_fsm_t;
endpackage

// ===== rtl/rpsem_drv_if.sv
// Link between the command sequencer and the per-drive state table
`timescale 1ns/1ps
interface rpsem_drv_if;
    import rpsem_pkg::*;
    logic                  wr;
    logic [2:0]            wr_drv;
    rpsem_dst_t            wr_st;
    logic                  clr;
    logic [2:0]            clr_drv;
    logic [NDRV-1:0][1:0]  st;
    logic [NDRV-1:0]       int_act;
    logic                  any_int;
    logic                  low_ok;
    logic [2:0]            low_drv;
    modport tbl (input wr, wr_drv, wr_st, clr, clr_drv,
                 output st, int_act, any_int, low_ok, low_drv);
    modport ctl (output wr, wr_drv, wr_st, clr, clr_drv,
                 input st, int_act, any_int, low_ok, low_drv);
endinterface

// ===== rtl/rpsem_drv_tbl.sv
// Per-drive state, pending device end and interrupt window table
`timescale 1ns/1ps
module rpsem_drv_tbl
    import rpsem_pkg::*;
#(
    parameter int WIN = WIN_CYC
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic [NDRV-1:0] motion_done,
    input  wire logic [NDRV-1:0] sector_hit,
    rpsem_drv_if.tbl             t
);
    typedef struct packed {
        logic [NDRV-1:0][1:0]  st;
        logic [NDRV-1:0]       dep;
        logic [NDRV-1:0][13:0] win;
    } rpsem_tbl_t;

    rpsem_tbl_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        t.low_ok = 1'b0;
        t.low_drv = 3'd0;
        for (int i = NDRV - 1; i >= 0; i--) begin
            if (s_q.win[i] != 14'd0)
                s_d.win[i] = s_q.win[i] - 14'd1;
            // Clear first, so the drive's own same-cycle event wins
            if (t.clr && t.clr_drv == 3'(i)) begin
                s_d.dep[i] = 1'b0;
                s_d.win[i] = 14'd0;
            end
            // Seek done while disconnected posts device end
            if (motion_done[i] && s_q.st[i] == DS_DCC)
                s_d.dep[i] = 1'b1;
            // One sector period per revolution
            if (sector_hit[i] && s_q.st[i] == DS_DCC)
                s_d.win[i] = 14'(WIN);
            if (t.wr && t.wr_drv == 3'(i))
                s_d.st[i] = t.wr_st;
            t.int_act[i] = s_q.dep[i] || s_q.win[i] != 14'd0;
            // Lowest numbered chaining drive with an interrupt
            if (t.int_act[i] && s_q.st[i] >= DS_DCC) begin
                t.low_ok = 1'b1;
                t.low_drv = 3'(i);
            end
        end
        t.st = s_q.st;
        t.any_int = |t.int_act;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule

// ===== verif/rpsem_assertions.sv
// Port checker for the position-mode command interpreter
`timescale 1ns/1ps
module rpsem_chk
    import rpsem_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [7:0] cmd_arg,
    input wire logic       cmd_count_ok,
    input wire logic       cmd_other_chan,
    input wire logic       select_out,
    input wire logic       address_out,
    input wire logic       sts_valid,
    input wire logic [7:0] sts_byte,
    input wire logic       sts_chained,
    input wire logic       request_in,
    input wire logic       sel_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Other-channel commands may be answered busy, so they are left out
    wire pm = cmd_valid && cmd_op == OP_POSMODE && !cmd_other_chan;
    wire dg = cmd_valid && cmd_op inside {OP_DIAGLD, OP_DIAGWR};
    ////////////////////////////////////////////////////////////
    AST_PM_ANSWER: assert property (
        pm |=> sts_valid) else $error("no status for position cmd");
    AST_SHORT_COUNT: assert property (
        pm && !cmd_count_ok |=> sts_byte[1]) else $error("short count ok");
    AST_INVALID_OP: assert property (
        pm && cmd_arg[1:0] == SC_INVALID |=> sts_byte[1] && !sts_byte[0])
        else $error("invalid state code accepted");
    AST_RSV_BITS: assert property (
        pm && cmd_arg[7:2] != 6'h00 |=> sts_byte[1])
        else $error("reserved state code bits accepted");
    AST_DIAG: assert property (
        dg |=> !sts_byte[0] && !sts_byte[6]) else $error("diag disconnect");
    AST_DISCONNECT: assert property (
        sts_valid && sts_byte[0] |-> sts_byte == (ST_CE | ST_UC | ST_UE))
        else $error("malformed disconnect status");
    AST_POLL_TAGS: assert property (
        $rose(sel_valid) |-> $past(select_out) && !$past(address_out)
        && $past(request_in)) else $error("selection without poll");
    AST_POLL_DE: assert property (
        sel_valid |=> sts_valid && sts_byte[2] && !sts_byte[1])
        else $error("no device end after selection");
    AST_CHAINED: assert property (
        sts_chained |-> sts_valid) else $error("chained flag alone");
    cover property (sel_valid);
    cover property (sts_valid && sts_byte[0]);
    cover property (sts_chained);
endmodule

bind rpsem_top rpsem_chk u_chk (.pclk, .presetn, .cmd_valid, .cmd_op,
    .cmd_arg, .cmd_count_ok, .cmd_other_chan, .select_out, .address_out,
    .sts_valid, .sts_byte, .sts_chained, .request_in, .sel_valid);

// ===== verif/rpsem_chan.sv
// Selector channel model that polls on request and stacks the status
`timescale 1ns/1ps
module rpsem_chan (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic poll_en,
    input  wire logic request_in,
    input  wire logic sts_valid,
    output logic      select_out,
    output logic      address_out,
    output logic      stack_in
);
    logic [1:0] ph_q;
    ////////////////////////////////////////////////////////////
    // A poll never carries an address
    assign address_out = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ph_q, select_out, stack_in} <= 4'h0;
        end else if (ph_q == 2'h0) begin
            select_out <= poll_en && request_in;
            ph_q       <= {1'b0, poll_en && request_in};
        end else if (ph_q == 2'h1) begin
            // Status is stacked, not taken, so device end stays pending
            stack_in <= sts_valid;
            ph_q     <= sts_valid ? 2'h2 : 2'h1;
        end else begin
            {ph_q, select_out, stack_in} <= 4'h0;
        end
    end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the position-mode command interpreter
`timescale 1ns/1ps
module testbench
    import rpsem_pkg::*;
();
    localparam logic [7:0]  F_OK = 8'h80, F_OTH = 8'h40, F_MOT = 8'h20;
    localparam logic [7:0]  F_SR = 8'h10, F_RTY = 8'h08, F_REC = 8'h04;
    localparam logic [7:0]  OP_RD = 8'h06;
    localparam logic [31:0] NS = 32'hFFFF_FFFF;
    typedef struct packed {
        logic [7:0]  op;
        logic [7:0]  arg;
        logic [2:0]  dv;
        logic [7:0]  fl;
        logic [7:0]  st;
        logic [7:0]  msk;
        logic [31:0] sn;
    } rpsem_row_t;
    logic            pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic            penable = 1'b0, pwrite = 1'b0, poll_en = 1'b0;
    logic            cmd_valid = 1'b0, cmd_count_ok = 1'b0;
    logic            cmd_other_chan = 1'b0, need_motion = 1'b0;
    logic            sector_ready = 1'b0, retry_cond = 1'b0;
    logic            recov_internal = 1'b0, er;
    logic [7:0]      paddr = 8'h00, cmd_op = 8'h00, cmd_arg = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    logic [2:0]      cmd_drive = 3'h0, sel_drive;
    logic [1:0]      err_cause = 2'h0;
    logic [NDRV-1:0] motion_done = '0, sector_hit = '0;
    logic [7:0]      sts_byte, sect_target;
    logic            pready, pslverr, select_out, address_out, stack_in;
    logic            sts_valid, sts_chained, retry_cmd, request_in, sel_valid;
    int              n_errors = 0, compares = 0;
    rpsem_row_t      rows [11];
    always #5 pclk = ~pclk;
    // Short interrupt window keeps the run brief
    rpsem_top #(.WIN(20)) DUT (.*);
    rpsem_chan u_chan (.*);
    ////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (k >= 50) begin
            n_errors++;
            close_out();
        end
    endtask
    // Waits on selection when s is set, otherwise on status
    task automatic wt(input logic s);
        int k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while ((s ? sel_valid : sts_valid) !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic cmd(input logic [7:0] op, a, input logic [2:0] dv,
                       input logic [7:0] fl);
        @(posedge pclk);
        {cmd_valid, cmd_op, cmd_arg, cmd_drive} <= {1'b1, op, a, dv};
        {cmd_count_ok, cmd_other_chan, need_motion, sector_ready,
         retry_cond, recov_internal, err_cause} <= fl;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        @(negedge pclk);
        chk("sts_valid", 32'h1, {31'h0, sts_valid});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        close_out();
    end
    initial begin
        rows = '{
            '{OP_DIAGLD, 8'h00, 3'h0, F_OK, 8'h0C, 8'hFF, NS},
            '{OP_DIAGWR, 8'h00, 3'h0, F_OK, 8'h0C, 8'hFF, NS},
            '{OP_RD, 8'h00, 3'h1, F_OK | F_RTY, 8'h0E, 8'hFF, 32'h0400_0000},
            '{OP_RD, 8'h00, 3'h1, F_OK | F_RTY | 8'h01, 8'h0E, 8'hFF,
              32'h0400_001A},
            '{OP_RD, 8'h00, 3'h1, F_OK | F_RTY | 8'h02, 8'h0E, 8'hFF,
              32'h0400_0040},
            '{OP_RD, 8'h00, 3'h1, F_OK | F_RTY | 8'h03, 8'h0E, 8'hFF,
              32'h0400_0050},
            '{OP_RD, 8'h00, 3'h1, F_OK | F_RTY | F_REC, 8'h0C, 8'hFF, NS},
            '{OP_SETSECT, 8'h10, 3'h1, F_OK | F_SR, 8'h0C, 8'hFF, NS},
            '{OP_POSMODE, 8'h00, 3'h1, F_OK, 8'h0E, 8'hFF, NS},
            '{OP_POSMODE, 8'h41, 3'h1, F_OK, 8'h02, 8'h02, NS},
            '{OP_POSMODE, 8'h01, 3'h1, 8'h00, 8'h02, 8'h02, 32'h8004_0000}
        };
        repeat (10) @(negedge pclk);
        chk("reset outs", 32'h4, {29'h0, pready, sts_valid, request_in});
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CTRL, 32'h0);
        chk("ctrl reset", CTRL_RST, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        foreach (rows[i]) begin
            cmd(rows[i].op, rows[i].arg, rows[i].dv, rows[i].fl);
            chk("status", {24'h0, rows[i].st & rows[i].msk},
                {24'h0, sts_byte & rows[i].msk});
            if (rows[i].sn !== NS) begin
                apb(1'b0, A_SENSE, 32'h0);
                chk("sense", rows[i].sn, rd);
            end
        end
        // Outside position mode the channel stays through the motion
        cmd(OP_SEEK, 8'h00, 3'h0, F_OK | F_MOT);
        chk("seek ce", 32'h08, {24'h0, sts_byte});
        @(posedge pclk);
        motion_done[0] <= 1'b1;
        @(posedge pclk);
        motion_done[0] <= 1'b0;
        wt(1'b0);
        chk("seek de", 32'h1, {31'h0, sts_byte[2]});
        apb(1'b1, A_CTRL, 32'h0);
        cmd(OP_POSMODE, 8'h01, 3'h1, F_OK);
        chk("bmx uc", 32'h1, {31'h0, sts_byte[1]});
        apb(1'b0, A_SENSE, 32'h0);
        chk("bmx sense", 32'h8001_0000, rd);
        apb(1'b1, A_CTRL, 32'h1);
        cmd(OP_POSMODE, 8'h01, 3'h2, F_OK);
        chk("enter", 32'h0C, {24'h0, sts_byte});
        cmd(OP_SEEK, 8'h00, 3'h2, F_OK | F_MOT);
        chk("disc", 32'h0B, {24'h0, sts_byte});
        cmd(OP_POSMODE, 8'h01, 3'h4, F_OK);
        cmd(OP_SETSECT, 8'h20, 3'h4, F_OK);
        chk("sect disc", 32'h0B, {24'h0, sts_byte});
        chk("target", 32'h19, {24'h0, sect_target});
        cmd(OP_RD, 8'h00, 3'h2, F_OK);
        chk("dcc uc", 32'h1, {31'h0, sts_byte[1]});
        cmd(OP_POSMODE, 8'h03, 3'h2, F_OK);
        chk("mismatch", 32'h0E, {24'h0, sts_byte});
        apb(1'b0, A_SENSE, 32'h0);
        chk("seq sense", 32'h8002_0000, rd);
        apb(1'b0, A_STAT, 32'h0);
        chk("states", 32'h220, {16'h0, rd[23:8]});
        motion_done[2] <= 1'b1;
        poll_en        <= 1'b1;
        @(posedge pclk);
        motion_done[2] <= 1'b0;
        wt(1'b1);
        chk("poll drive", 32'h2, {29'h0, sel_drive});
        @(posedge pclk);
        poll_en <= 1'b0;
        wt(1'b0);
        chk("poll de", 32'h04, {24'h0, sts_byte});
        repeat (4) @(negedge pclk);
        chk("req kept", 32'h1, {31'h0, request_in});
        cmd(OP_TIO, 8'h00, 3'h2, F_OK);
        chk("tio de", 32'h04, {24'h0, sts_byte});
        chk("int clear", 32'h0, {31'h0, request_in});
        cmd(OP_RD, 8'h00, 3'h5, F_OK);
        chk("other dev", 32'h1, {31'h0, sts_byte[1]});
        cmd(OP_RD, 8'h00, 3'h5, F_OK | F_OTH);
        chk("other chan", 32'h10, {24'h0, sts_byte});
        cmd(OP_POSMODE, 8'h02, 3'h2, F_OK);
        chk("recon", 32'h0C, {24'h0, sts_byte});
        cmd(OP_RD, 8'h00, 3'h2, F_OK);
        chk("chained", 32'h1, {31'h0, sts_chained});
        cmd(OP_RD, 8'h00, 3'h2, F_OK | F_RTY);
        chk("retry disc", 32'h4A, {24'h0, sts_byte});
        cmd(OP_POSMODE, 8'h03, 3'h2, F_OK);
        cmd(OP_RD, 8'h00, 3'h2, F_OK);
        chk("retry cmd", 32'h3, {30'h0, retry_cmd, sts_chained});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_STAT, 32'h0);
        chk("states rst", 32'h0, {8'h0, rd[23:0]});
        close_out();
    end
endmodule
